// ---- design/general_purpose_pin_port.sv ----
// Seven-pin general purpose port with optional data-ready on pin six
`timescale 1ns/1ps
// How it works
// - Seven direction bits, one means output, reset inputs
// - Output pins drive the written data bit
// - Data writes to input pins are silently ignored
// - Reading output pins returns the pin level as sampled through the two-flop synchroniser
// - Data-ready role overrides pin six direction and data
// - Control bit seven selects data-ready on pin six
module general_purpose_pin_port (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET,
   // Register access from the serial interface
   input wire gpio_port_pkg::reg_request_t REG_REQ,
   output logic [7:0] REG_RDATA,
   output logic REG_HIT,
   // Data-ready from the converter core, active low
   input wire logic DATA_READY_N,
   // Port pins
   input wire logic [6:0] PORT_PIN_IN,
   output gpio_port_pkg::pin_drive_t PORT_PIN
);
   // Register state
   logic [6:0] pin_direction_control;
   logic [6:0] pin_level_data;
   logic ready_on_pin_six_select;
   logic [6:0] ready_control_other;

   // Pin sampling and read path
   logic [6:0] pin_level_sync;
   logic [6:0] readback;
   logic [7:0] next_rdata;
   logic next_hit;

   // Next values of stored data and pin drive
   logic [6:0] next_level;
   logic [6:0] next_oe;
   logic [6:0] next_out;

   // Decoded strobes
   logic dir_write;
   logic level_write;
   logic ctrl_write;
   logic dir_read;
   logic level_read;
   logic ctrl_read;

   // One decoder for every strobe, so reads and writes share one address map
   function automatic logic reg_match(
      input gpio_port_pkg::reg_request_t req,
      input logic [6:0] offset,
      input logic is_write
   );
      logic kind;
      kind = is_write ? req.write : req.read;
      return kind && (req.address == offset);
   endfunction : reg_match

   // Input-pin bits keep their old value, so a later direction change drives no stale write
   function automatic logic [6:0] merge_level(
      input logic [6:0] stored,
      input logic [6:0] written,
      input logic [6:0] direction
   );
      return (written & direction) | (stored & ~direction);
   endfunction : merge_level

   // The data-ready role forces pin six to drive, whatever its direction bit says
   function automatic logic [6:0] pin_enable(
      input logic [6:0] direction,
      input logic select
   );
      logic [6:0] result;
      result = direction;
      if (select) begin
         result[gpio_port_pkg::PIN_SIX_INDEX] = 1'b1;
      end
      return result;
   endfunction : pin_enable

   // Disabled buffers see a low level, so a stored bit never leaks out of an input pin
   function automatic logic [6:0] pin_value(
      input logic [6:0] stored,
      input logic [6:0] direction,
      input logic select,
      input logic ready_n
   );
      logic [6:0] result;
      result = stored & direction;
      if (select) begin
         result[gpio_port_pkg::PIN_SIX_INDEX] = ready_n;
      end
      return result;
   endfunction : pin_value

   // Write strobes
   always_comb begin
      dir_write = reg_match(REG_REQ, gpio_port_pkg::DIRECTION_OFFSET, 1'b1);
      level_write = reg_match(REG_REQ, gpio_port_pkg::LEVEL_OFFSET, 1'b1);
      ctrl_write = reg_match(REG_REQ, gpio_port_pkg::READY_CONTROL_OFFSET, 1'b1);
   end

   // Read strobes
   always_comb begin
      dir_read = reg_match(REG_REQ, gpio_port_pkg::DIRECTION_OFFSET, 1'b0);
      level_read = reg_match(REG_REQ, gpio_port_pkg::LEVEL_OFFSET, 1'b0);
      ctrl_read = reg_match(REG_REQ, gpio_port_pkg::READY_CONTROL_OFFSET, 1'b0);
   end

   pin_input_sync #(.WIDTH(gpio_port_pkg::PIN_COUNT)) u_sync (
      .clk(CLK_SYS),
      .reset(RESET),
      .async_in(PORT_PIN_IN),
      .sync_out(pin_level_sync)
   );

   // All inputs after reset, so nothing fights the board before software decides
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         pin_direction_control <= gpio_port_pkg::DIRECTION_RESET;
      end else if (dir_write) begin
         pin_direction_control <= REG_REQ.wdata[6:0];
      end
   end

   always_comb begin
      next_level = merge_level(pin_level_data, REG_REQ.wdata[6:0],
         pin_direction_control);
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         pin_level_data <= gpio_port_pkg::LEVEL_RESET;
      end else if (level_write) begin
         pin_level_data <= next_level;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         ready_on_pin_six_select <= gpio_port_pkg::READY_SELECT_RESET;
      end else if (ctrl_write) begin
         ready_on_pin_six_select <= REG_REQ.wdata[gpio_port_pkg::READY_SELECT_BIT];
      end
   end

   // Other control bits are kept only so software reads back what it wrote
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         ready_control_other <= 7'(gpio_port_pkg::READY_CONTROL_OTHER_RESET);
      end else if (ctrl_write) begin
         ready_control_other <= REG_REQ.wdata[6:0];
      end
   end

   always_comb begin
      next_oe = pin_enable(pin_direction_control, ready_on_pin_six_select);
   end

   always_comb begin
      next_out = pin_value(pin_level_data, pin_direction_control,
         ready_on_pin_six_select, DATA_READY_N);
   end

   // Registered drive costs a cycle of lag but keeps decode glitches off the pins
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         PORT_PIN <= '0;
      end else begin
         PORT_PIN.oe <= next_oe;
         PORT_PIN.out <= next_out;
      end
   end

   // Reads show the sampled pin for every bit, which for outputs is the driven level
   always_comb begin
      readback = pin_level_sync;
   end

   // Unmapped reads return zero with no hit
   always_comb begin
      next_rdata = 8'h00;
      next_hit = 1'b0;
      if (dir_read) begin
         next_rdata = {1'b0, pin_direction_control};
         next_hit = 1'b1;
      end
      if (level_read) begin
         next_rdata = {1'b0, readback};
         next_hit = 1'b1;
      end
      if (ctrl_read) begin
         next_rdata = {ready_on_pin_six_select, ready_control_other};
         next_hit = 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         REG_RDATA <= 8'h00;
      end else begin
         REG_RDATA <= next_rdata;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         REG_HIT <= 1'b0;
      end else begin
         REG_HIT <= next_hit;
      end
   end
endmodule : general_purpose_pin_port

// ---- design/gpio_port_pkg.sv ----
// Package: register map, field positions and reset values of the pin port
package gpio_port_pkg;
   localparam int PIN_COUNT = 7;
   localparam logic [6:0] DIRECTION_OFFSET = 7'h0E;
   localparam logic [6:0] LEVEL_OFFSET = 7'h0F;
   localparam logic [6:0] READY_CONTROL_OFFSET = 7'h11;
   localparam int READY_SELECT_BIT = 7;
   localparam int PIN_SIX_INDEX = 6;
   localparam logic [6:0] DIRECTION_RESET = 7'h00;
   localparam logic [6:0] LEVEL_RESET = 7'h00;
   localparam logic READY_SELECT_RESET = 1'b0;
   localparam logic [7:0] READY_CONTROL_OTHER_RESET = 8'h03;

   typedef struct packed {
      logic write;
      logic read;
      logic [6:0] address;
      logic [7:0] wdata;
   } reg_request_t;

   typedef struct packed {
      logic [6:0] out;
      logic [6:0] oe;
   } pin_drive_t;
endpackage : gpio_port_pkg

// ---- design/pin_input_sync.sv ----
// Two-flop synchroniser for the port pin inputs
`timescale 1ns/1ps
module pin_input_sync #(
   parameter int WIDTH = 7
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage_one;

   always_ff @(posedge clk) begin
      if (reset) begin
         stage_one <= '0;
         sync_out <= '0;
      end else begin
         stage_one <= async_in;
         sync_out <= stage_one;
      end
   end
endmodule : pin_input_sync

// ---- dv/general_purpose_pin_port_asserts.sv ----
// Checker for the pin port
`timescale 1ns/1ps
module general_purpose_pin_port_asserts (
   // Ports of the pin port
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire gpio_port_pkg::reg_request_t REG_REQ,
   input wire logic [7:0] REG_RDATA,
   input wire logic REG_HIT,
   input wire logic DATA_READY_N,
   input wire logic [6:0] PORT_PIN_IN,
   input wire gpio_port_pkg::pin_drive_t PORT_PIN
);
   default clocking @(posedge CLK_SYS);
   endclocking
   default disable iff (RESET);
   logic w;
   logic [6:0] a;
   assign w = REG_REQ.write;
   assign a = REG_REQ.address;
   a_reset_inputs: assert property ($fell(RESET) |-> PORT_PIN.oe == 7'h00)
      else $error("oe after reset");
   a_dir_cause: assert property ($rose(PORT_PIN.oe[0]) |-> $past(w, 2) && $past(a, 2) == 7'h0E)
      else $error("oe without write");
   a_level_drive: assert property (w && a == 7'h0F && PORT_PIN.oe[0]
      && !$past(w && a == 7'h0E) ##1 !w
      |=> PORT_PIN.out[0] == $past(REG_REQ.wdata[0], 2)) else $error("drive level");
   a_input_hold: assert property (w && a == 7'h0F && !PORT_PIN.oe[0]
      && !$past(w && a == 7'h0E) ##1 !w
      |=> $stable(PORT_PIN.out[0])) else $error("input write");
   a_read_level: assert property (REG_REQ.read && a == 7'h0F
      |=> REG_HIT && REG_RDATA == {1'b0, $past(PORT_PIN_IN, 3)}) else $error("level read");
   a_ready_select: assert property (w && a == 7'h11 && REG_REQ.wdata[7] ##1 !w
      |=> PORT_PIN.oe[6]) else $error("ready select");
   a_ready_level: assert property (w && a == 7'h11 && REG_REQ.wdata[7] ##1 !w
      |=> PORT_PIN.out[6] == $past(DATA_READY_N)) else $error("ready level");
endmodule : general_purpose_pin_port_asserts

// ---- dv/pin_board.sv ----
// Board model: external levels on the port pins
`timescale 1ns/1ps
module pin_board (
   // Port drive and board levels
   input wire gpio_port_pkg::pin_drive_t drive,
   input wire logic [6:0] ext_level,
   output logic [6:0] level
);
   // Board level shows only where the port is not driving
   assign level = (drive.out & drive.oe) | (ext_level & ~drive.oe);
endmodule : pin_board

// ---- dv/general_purpose_pin_port_tb.sv ----
// Bench for the pin port
`timescale 1ns/1ps
module general_purpose_pin_port_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rdy_n = 1'b1;
   gpio_port_pkg::reg_request_t req = '0;
   gpio_port_pkg::pin_drive_t pin;
   logic [7:0] rd;
   logic hit;
   logic [6:0] lvl;
   int mismatches = 0;
   int n_checks = 0;
   always #2.5 clk = ~clk;
   general_purpose_pin_port uut (.CLK_SYS(clk), .RESET(rst), .REG_REQ(req), .REG_RDATA(rd),
      .REG_HIT(hit), .DATA_READY_N(rdy_n), .PORT_PIN_IN(lvl), .PORT_PIN(pin));
   pin_board board (.drive(pin), .ext_level(7'h6A), .level(lvl));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask : chk
   // Writes wait out register, pin flop and synchroniser before returning
   task automatic go(input logic w, input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{w, !w, a, d};
      @(posedge clk);
      req <= '0;
      repeat (w ? 4 : 0) @(posedge clk);
      #1;
   endtask : go
   task automatic rdc(input logic [6:0] a, input logic [7:0] e);
      go(1'b0, a, 8'h00);
      chk("read", e, rd);
      chk("hit", {7'h00, a != 7'h10}, {7'h00, hit});
   endtask : rdc
   task automatic drive_read;
      chk("oe", 8'h00, {1'b0, pin.oe});
      rdc(7'h11, 8'h03);
      go(1'b1, 7'h0E, 8'h3F);
      rdc(7'h0E, 8'h3F);
      go(1'b1, 7'h0F, 8'h15);
      chk("oe", 8'h3F, {1'b0, pin.oe});
      rdc(7'h0F, 8'h55);
   endtask : drive_read
   task automatic input_write;
      go(1'b1, 7'h0E, 8'h00);
      go(1'b1, 7'h0F, 8'hFF);
      rdc(7'h0F, 8'h6A);
      go(1'b1, 7'h0E, 8'h7F);
      chk("out", 8'h15, {1'b0, pin.out});
   endtask : input_write
   task automatic ready_pin;
      go(1'b1, 7'h0E, 8'h3F);
      go(1'b1, 7'h0F, 8'h40);
      @(posedge clk);
      rdy_n <= 1'b0;
      go(1'b1, 7'h11, 8'h83);
      chk("pin six", 8'h02, {6'h00, pin.oe[6], pin.out[6]});
      rdc(7'h11, 8'h83);
      rdc(7'h0F, 8'h00);
      go(1'b1, 7'h0E, 8'h7F);
      @(posedge clk);
      rdy_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("pin six", 8'h03, {6'h00, pin.oe[6], pin.out[6]});
      rdc(7'h0F, 8'h40);
      go(1'b1, 7'h11, 8'h03);
      chk("pin six", 8'h02, {6'h00, pin.oe[6], pin.out[6]});
      rdc(7'h10, 8'h00);
   endtask : ready_pin
   task automatic finish_test;
      $display("checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      drive_read();
      input_write();
      ready_pin();
      finish_test();
   end
endmodule : general_purpose_pin_port_tb
bind general_purpose_pin_port general_purpose_pin_port_asserts chk_i (.CLK_SYS, .RESET,
   .REG_REQ, .REG_RDATA, .REG_HIT, .DATA_READY_N, .PORT_PIN_IN, .PORT_PIN);
